// ===== shared/ppm_map.vh
`ifndef PPM_MAP_VH
`define PPM_MAP_VH
// pad configuration word layout
`define PPM_CFG_W 5
`define PPM_CFG_FUNC_LSB 0
`define PPM_CFG_FUNC_MSB 1
`define PPM_CFG_INBUF_BIT 2
`define PPM_CFG_SLEW_BIT 3
`define PPM_CFG_RST 5'h0_0
// function choices
`define PPM_FUNC_ALT0 2'h0
`define PPM_FUNC_ALT1 2'h1
`define PPM_FUNC_ALT2 2'h2
`define PPM_FUNC_ALT3 2'h3
// pad indices inside the block
`define PPM_PAD_A2 0
`define PPM_PAD_A3 1
`define PPM_PAD_A4 2
`define PPM_PAD_A5 3
`define PPM_PAD_A7 4
`define PPM_PAD_A8 5
`define PPM_PAD_G9 6
`define PPM_PAD_G10 7
`define PPM_NPADS 8
// source select for the spi unit 1 data input
`define PPM_SRC_A8 1'h0
`define PPM_SRC_RST 1'h0
`endif

// ===== src/ppm_pin_mux.v
// Behaviour
// - reset selects choice zero, general I/O
// - field 00..11 routes choice zero..three
// - input buffer enable gates input-only paths
// - pad input fans out to all users
// - source select picks pad for shared input
// - slew bit: 0 slow, 1 medium
// - boot pins pulled down during reset
// - A5: gpio, spi1 cs0, timer 1 ch5, spi0 cs7, irq5
// - A7: gpio, spi1 data out, spi4 cs1, irq7
// - A8: gpio, spi4 cs0; feeds spi1 in, irq8
`timescale 1ns/100ps
`default_nettype none
`include "ppm_map.vh"
module ppm_pin_mux #(
   parameter NPADS = `PPM_NPADS
) (
   input wire mclk,
   input wire rstn,
   // configuration write port, one pad per write
   input wire cfgWrEn,
   input wire [2:0] cfgPadSel,
   input wire [`PPM_CFG_W-1:0] cfgWrData,
   input wire srcWrEn,
   input wire srcWrData,
   output wire [`PPM_CFG_W*NPADS-1:0] cfgRdData,
   output wire srcRdData,
   // pads
   input wire [NPADS-1:0] padIn,
   output reg [NPADS-1:0] padOut,
   output reg [NPADS-1:0] padOe,
   output wire [NPADS-1:0] padSlewMed,
   output wire [NPADS-1:0] padPullDown,
   // gpio side
   input wire [NPADS-1:0] gpioOut,
   input wire [NPADS-1:0] gpioOe,
   output wire [NPADS-1:0] gpioIn,
   // peripheral outputs
   input wire tmrCh2Out,
   input wire tmrCh2Oe,
   input wire tmrCh3Out,
   input wire tmrCh3Oe,
   input wire tmr1Ch0Out,
   input wire tmr1Ch0Oe,
   input wire tmrCh4Out,
   input wire tmrCh4Oe,
   input wire tmr1Ch5Out,
   input wire tmr1Ch5Oe,
   input wire spi4Cs3,
   input wire spi2Cs0,
   input wire spi2Cs1,
   input wire spi1Cs0,
   input wire spi0Cs7,
   input wire spi1DataOut,
   input wire spi4Cs1,
   input wire spi4Cs0,
   input wire can1Tx,
   // peripheral inputs
   output wire [2:0] bootSelectInput,
   output wire [8:2] extInterruptLine,
   output wire spi1DataIn,
   output wire spi2DataIn,
   output wire can1Rx
);
   reg [`PPM_CFG_W-1:0] cfg_q [0:NPADS-1];
   reg srcSel_q;
   wire [NPADS-1:0] input_buffer_en;
   integer i;
   integer j;
   // register write lands at the next edge
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (i = 0; i < NPADS; i = i + 1) begin
            cfg_q[i] <= `PPM_CFG_RST;
         end
         srcSel_q <= `PPM_SRC_RST;
      end else begin
         if (cfgWrEn && (cfgPadSel < NPADS)) begin
            cfg_q[cfgPadSel] <= cfgWrData;
         end
         if (srcWrEn) begin
            srcSel_q <= srcWrData;
         end
      end
   end
   genvar g;
   generate
      for (g = 0; g < NPADS; g = g + 1) begin : gPad
         assign cfgRdData[`PPM_CFG_W*g +: `PPM_CFG_W] = cfg_q[g];
         assign padSlewMed[g] = cfg_q[g][`PPM_CFG_SLEW_BIT];
         assign input_buffer_en[g] = cfg_q[g][`PPM_CFG_INBUF_BIT];
      end
   endgenerate
   assign srcRdData = srcSel_q;
   // pull-down on boot select pins during reset
   assign padPullDown = {{(NPADS-3){1'b0}}, {3{~rstn}}};
   // gpio input always visible
   assign gpioIn = padIn;
   // input-only functions need the input buffer enable
   assign bootSelectInput = {padIn[`PPM_PAD_A4] & input_buffer_en[`PPM_PAD_A4], padIn[`PPM_PAD_A3] & input_buffer_en[`PPM_PAD_A3],
      padIn[`PPM_PAD_A2] & input_buffer_en[`PPM_PAD_A2]};
   assign extInterruptLine[2] = padIn[`PPM_PAD_A2] & input_buffer_en[`PPM_PAD_A2];
   assign extInterruptLine[3] = padIn[`PPM_PAD_A3] & input_buffer_en[`PPM_PAD_A3];
   assign extInterruptLine[4] = padIn[`PPM_PAD_A4] & input_buffer_en[`PPM_PAD_A4];
   assign extInterruptLine[5] = padIn[`PPM_PAD_A5] & input_buffer_en[`PPM_PAD_A5];
   assign extInterruptLine[6] = 1'b0;
   assign extInterruptLine[7] = padIn[`PPM_PAD_A7] & input_buffer_en[`PPM_PAD_A7];
   assign extInterruptLine[8] = padIn[`PPM_PAD_A8] & input_buffer_en[`PPM_PAD_A8];
   assign spi2DataIn = padIn[`PPM_PAD_A2] & input_buffer_en[`PPM_PAD_A2];
   // only one source pad today; select value 1 disconnects it and spi1DataIn reads 0
   assign spi1DataIn = (srcSel_q == `PPM_SRC_A8) ? (padIn[`PPM_PAD_A8] & input_buffer_en[`PPM_PAD_A8]) : 1'b0;
   assign can1Rx = padIn[`PPM_PAD_G9] & input_buffer_en[`PPM_PAD_G9];
   // output selection, unused choices leave the pad undriven
   always @* begin
      padOut = {NPADS{1'b0}};
      padOe = {NPADS{1'b0}};
      for (j = 0; j < NPADS; j = j + 1) begin
         if (cfg_q[j][`PPM_CFG_FUNC_MSB:`PPM_CFG_FUNC_LSB] == `PPM_FUNC_ALT0) begin
            padOut[j] = gpioOut[j];
            padOe[j] = gpioOe[j];
         end
      end
      case (cfg_q[`PPM_PAD_A2][`PPM_CFG_FUNC_MSB:`PPM_CFG_FUNC_LSB])
         `PPM_FUNC_ALT1: begin
            padOut[`PPM_PAD_A2] = tmrCh2Out;
            padOe[`PPM_PAD_A2] = tmrCh2Oe;
         end
         `PPM_FUNC_ALT2: begin
            padOut[`PPM_PAD_A2] = spi4Cs3;
            padOe[`PPM_PAD_A2] = 1'b1;
         end
         default: begin
         end
      endcase
      case (cfg_q[`PPM_PAD_A3][`PPM_CFG_FUNC_MSB:`PPM_CFG_FUNC_LSB])
         `PPM_FUNC_ALT1: begin
            padOut[`PPM_PAD_A3] = tmrCh3Out;
            padOe[`PPM_PAD_A3] = tmrCh3Oe;
         end
         `PPM_FUNC_ALT2: begin
            padOut[`PPM_PAD_A3] = spi2Cs0;
            padOe[`PPM_PAD_A3] = 1'b1;
         end
         default: begin
         end
      endcase
      case (cfg_q[`PPM_PAD_A4][`PPM_CFG_FUNC_MSB:`PPM_CFG_FUNC_LSB])
         `PPM_FUNC_ALT1: begin
            padOut[`PPM_PAD_A4] = tmr1Ch0Out;
            padOe[`PPM_PAD_A4] = tmr1Ch0Oe;
         end
         `PPM_FUNC_ALT2: begin
            padOut[`PPM_PAD_A4] = spi2Cs1;
            padOe[`PPM_PAD_A4] = 1'b1;
         end
         `PPM_FUNC_ALT3: begin
            padOut[`PPM_PAD_A4] = tmrCh4Out;
            padOe[`PPM_PAD_A4] = tmrCh4Oe;
         end
         default: begin
         end
      endcase
      case (cfg_q[`PPM_PAD_A5][`PPM_CFG_FUNC_MSB:`PPM_CFG_FUNC_LSB])
         `PPM_FUNC_ALT1: begin
            padOut[`PPM_PAD_A5] = spi1Cs0;
            padOe[`PPM_PAD_A5] = 1'b1;
         end
         `PPM_FUNC_ALT2: begin
            padOut[`PPM_PAD_A5] = tmr1Ch5Out;
            padOe[`PPM_PAD_A5] = tmr1Ch5Oe;
         end
         `PPM_FUNC_ALT3: begin
            padOut[`PPM_PAD_A5] = spi0Cs7;
            padOe[`PPM_PAD_A5] = 1'b1;
         end
         default: begin
         end
      endcase
      case (cfg_q[`PPM_PAD_A7][`PPM_CFG_FUNC_MSB:`PPM_CFG_FUNC_LSB])
         `PPM_FUNC_ALT1: begin
            padOut[`PPM_PAD_A7] = spi1DataOut;
            padOe[`PPM_PAD_A7] = 1'b1;
         end
         `PPM_FUNC_ALT2: begin
            padOut[`PPM_PAD_A7] = spi4Cs1;
            padOe[`PPM_PAD_A7] = 1'b1;
         end
         default: begin
         end
      endcase
      if (cfg_q[`PPM_PAD_A8][`PPM_CFG_FUNC_MSB:`PPM_CFG_FUNC_LSB] == `PPM_FUNC_ALT2) begin
         padOut[`PPM_PAD_A8] = spi4Cs0;
         padOe[`PPM_PAD_A8] = 1'b1;
      end
      if (cfg_q[`PPM_PAD_G10][`PPM_CFG_FUNC_MSB:`PPM_CFG_FUNC_LSB] == `PPM_FUNC_ALT2) begin
         padOut[`PPM_PAD_G10] = can1Tx;
         padOe[`PPM_PAD_G10] = 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/ppm_pad_env.sv
`timescale 1ns/100ps
`default_nettype none
module ppm_pad_env (
   input wire logic [7:0] padOut,
   input wire logic [7:0] padOe,
   input wire logic [7:0] padPullDown,
   input wire logic [7:0] extEn,
   input wire logic [7:0] extVal,
   output logic [7:0] padIn
);
   // a floating pad shows the inverse of its current padOut, a pulled pad its pull level
   assign padIn = (padOe & padOut) | (~padOe & extEn & extVal) | (~padOe & ~extEn & ~padPullDown & ~padOut);
endmodule
`default_nettype wire

// ===== testbench/ppm_pin_mux_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module ppm_pin_mux_asserts (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic cfgWrEn,
   input wire logic [2:0] cfgPadSel,
   input wire logic [4:0] cfgWrData,
   input wire logic [39:0] cfgRdData,
   input wire logic srcRdData,
   input wire logic [7:0] padIn,
   input wire logic [7:0] padOut,
   input wire logic [7:0] padOe,
   input wire logic [7:0] padSlewMed,
   input wire logic [7:0] padPullDown,
   input wire logic spi1Cs0,
   input wire logic can1Tx,
   input wire logic spi1DataIn,
   input wire logic can1Rx
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence padWrite; cfgWrEn ##1 1'b1; endsequence
   cfg_reset_a: assert property ($rose(rstn) |-> cfgRdData == 40'h0 && !srcRdData) else $error("cfg not clear");
   cfg_write_a: assert property (padWrite |-> cfgRdData[5*$past(cfgPadSel)+:5] == $past(cfgWrData)) else $error("cfg");
   cfg_hold_a: assert property (!cfgWrEn |=> $stable(cfgRdData)) else $error("cfg moved");
   slew_map_a: assert property (padSlewMed[7] == cfgRdData[38]) else $error("slew");
   pull_off_a: assert property (padPullDown == 8'h00) else $error("pulldown");
   a5_select_a: assert property (cfgRdData[16:15] == 2'h1 |-> padOe[3] && padOut[3] == spi1Cs0) else $error("a5");
   g10_tx_a: assert property (cfgRdData[36:35] == 2'h2 |-> padOe[7] && padOut[7] == can1Tx) else $error("g10");
   can_rx_a: assert property (can1Rx == (cfgRdData[32] & padIn[6])) else $error("rx");
   spi_src_a: assert property (spi1DataIn == (!srcRdData & cfgRdData[27] & padIn[5])) else $error("sin");
endmodule
bind ppm_pin_mux ppm_pin_mux_asserts u_ppm_pin_mux_asserts (.*);
`default_nettype wire

// ===== testbench/ppm_pin_mux_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin testsRun++; if ((a) !== (e)) begin errTotal++; $display("wrong value %s exp %h got %h", n, e, a); end end
module ppm_pin_mux_tb;
   logic mclk = 0, rstn = 0, cfgWrEn = 0, srcWrEn = 0, srcWrData = 0;
   logic [2:0] cfgPadSel = 0;
   logic [4:0] cfgWrData = 0;
   logic [7:0] gpioOut = 8'h5A, gpioOe = 8'hFF, extEn = 0, extVal = 0;
   logic [18:0] per = 19'h5_A5A5;
   wire [39:0] cfgRdData;
   wire [7:0] padIn, padOut, padOe, padSlewMed, padPullDown;
   wire srcRdData, spi1DataIn, can1Rx, spi2DataIn;
   wire [7:0] gpioIn;
   wire [2:0] bootSelectInput;
   wire [8:2] extInterruptLine;
   int errTotal = 0, testsRun = 0, cyc = 0;
   ppm_pin_mux u_ppm_pin_mux (.*, .tmrCh2Out(per[0]), .tmrCh2Oe(per[1]),
      .tmrCh3Out(per[2]), .tmrCh3Oe(per[3]), .tmr1Ch0Out(per[4]), .tmr1Ch0Oe(per[5]), .tmrCh4Out(per[6]),
      .tmrCh4Oe(per[7]), .tmr1Ch5Out(per[8]), .tmr1Ch5Oe(per[9]), .spi4Cs3(per[10]), .spi2Cs0(per[11]),
      .spi2Cs1(per[12]), .spi1Cs0(per[13]), .spi0Cs7(per[14]), .spi1DataOut(per[15]), .spi4Cs1(per[16]),
      .spi4Cs0(per[17]), .can1Tx(per[18]));
   ppm_pad_env u_ppm_pad_env (.padOut(padOut), .padOe(padOe), .padPullDown(padPullDown), .extEn(extEn),
      .extVal(extVal), .padIn(padIn));
   initial forever #25 mclk = ~mclk;
   always @(posedge mclk) if (++cyc > 400) begin errTotal++; completeRun(); end
   task automatic completeRun;
      if (errTotal == 0 && testsRun > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [2:0] p, input logic [4:0] d);
      @(posedge mclk) begin cfgWrEn <= 1; cfgPadSel <= p; cfgWrData <= d; end
      @(posedge mclk) cfgWrEn <= 0;
      #1;
   endtask
   task automatic tRst;
      repeat (2) @(posedge mclk);
      #1 `CHK("pull", 8'h07, padPullDown)
      `CHK("cfg", 40'h0, cfgRdData)
      `CHK("gpio", {gpioOe, gpioOut}, {padOe, padOut})
      @(posedge mclk) rstn <= 1;
      @(posedge mclk) #1 `CHK("pull off", 8'h00, padPullDown)
   endtask
   task automatic tFunc;
      logic [3:0] o[7], e[7];
      int pi[7] = '{0, 1, 2, 3, 4, 5, 7};
      for (int j = 0; j < 2; j++) begin
         @(posedge mclk) begin per <= ~per; gpioOut <= ~gpioOut; end
         for (int k = 0; k < 4; k++) begin
            for (int p = 0; p < 7; p++) wr(3'(pi[p]), 5'(k));
            o = '{{1'b0, per[10], per[0], gpioOut[0]}, {1'b0, per[11], per[2], gpioOut[1]},
               {per[6], per[12], per[4], gpioOut[2]},
               {per[14], per[8], per[13], gpioOut[3]}, {1'b0, per[16], per[15], gpioOut[4]},
               {1'b0, per[17], 1'b0, gpioOut[5]}, {1'b0, per[18], 1'b0, gpioOut[7]}};
            e = '{{2'b01, per[1], gpioOe[0]}, {2'b01, per[3], gpioOe[1]}, {per[7], 1'b1, per[5], gpioOe[2]},
               {1'b1, per[9], 1'b1, gpioOe[3]}, {3'b011, gpioOe[4]}, {3'b010, gpioOe[5]}, {3'b010, gpioOe[7]}};
            for (int p = 0; p < 7; p++)
               `CHK("mux", {e[p][k], e[p][k] & o[p][k]}, {padOe[pi[p]], padOe[pi[p]] & padOut[pi[p]]})
         end
      end
   endtask
   task automatic tIn;
      @(posedge mclk) begin gpioOe <= 8'h00; extEn <= 8'h6F; extVal <= 8'hFA; end
      #1 `CHK("gated", 7'h00, {extInterruptLine[8], spi1DataIn, can1Rx, bootSelectInput, spi2DataIn})
      wr(3'h0, 5'h04);
      wr(3'h1, 5'h04);
      wr(3'h2, 5'h04);
      `CHK("boot", 10'h124, {gpioIn[2:0], bootSelectInput, extInterruptLine[4:2], spi2DataIn})
      wr(3'h5, 5'h07);
      wr(3'h6, 5'h04);
      `CHK("fanout", 3'h7, {extInterruptLine[8], spi1DataIn, can1Rx})
      @(posedge mclk) begin srcWrEn <= 1; srcWrData <= 1; end
      @(posedge mclk) srcWrEn <= 0;
      #1 `CHK("source", 3'h5, {extInterruptLine[8], spi1DataIn, srcRdData})
      wr(3'h7, 5'h08);
      `CHK("slew", 8'h80, padSlewMed)
   endtask
   initial begin
      tRst();
      tFunc();
      tIn();
      completeRun();
   end
endmodule
`default_nettype wire
